/* hw/pms_pkg.sv */
// Package for the power mode supervisor: register map, field positions,
// mode encodings and the packed structs carried between logic groups.
// Assumes a 32-bit APB slave with word-aligned registers.
package pms_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SUPV = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_PULL = 8'h0C;
    localparam logic [7:0] OFF_CLR = 8'h10;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;       // Three-bit requested mode.
    localparam int CTRL_GO_BIT = 3;         // Write one to enter the requested mode.
    localparam int CTRL_RET_BIT = 4;        // SRAM retention in standby.
    localparam int CTRL_WKPOL_BIT = 5;      // Wakeup pin polarity, 1 = falling.
    localparam int CTRL_LPRUN_BIT = 6;      // Low-power run select.
    localparam int CTRL_CLKDIV_LSB = 8;     // Processor clock divider code.

    // Supervisor register fields.
    localparam int SUPV_STD_EN_BIT = 0;     // Threshold detector enable.
    localparam int SUPV_FALL_BIT = 1;
    localparam int SUPV_RISE_BIT = 2;
    localparam int SUPV_FLAG_BIT = 3;       // Sticky crossing flag (status).
    localparam int CLR_FLAG_BIT = 0;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] SUPV_RESET = 32'h0000_0000;
    localparam logic [31:0] PULL_RESET = 32'h0000_0000;

    // Low-power run clock ceiling: 2 MHz from a 50 MHz bus clock.
    localparam int PCLK_HZ = 50_000_000;
    localparam int LPRUN_MAX_HZ = 2_000_000;
    localparam int LPRUN_MIN_DIV = (PCLK_HZ + LPRUN_MAX_HZ - 1) / LPRUN_MAX_HZ;

    // Start-up sequence length after a deep wakeup, in pclk cycles.
    localparam int STARTUP_CYCLES = 16;

    // ------------------------------------------------------------------
    // Mode codes written into the mode field
    // ------------------------------------------------------------------
    localparam logic [2:0] REQ_SLEEP = 3'h1;
    localparam logic [2:0] REQ_STOP0 = 3'h2;
    localparam logic [2:0] REQ_STOP1 = 3'h3;
    localparam logic [2:0] REQ_STANDBY = 3'h4;
    localparam logic [2:0] REQ_SHUTDOWN = 3'h5;

    typedef enum logic [8:0] {
        ST_RUN = 9'b0_0000_0001,
        ST_SLEEP = 9'b0_0000_0010,
        ST_LPRUN = 9'b0_0000_0100,
        ST_LPSLEEP = 9'b0_0000_1000,
        ST_STOP0 = 9'b0_0001_0000,
        ST_STOP1 = 9'b0_0010_0000,
        ST_STANDBY = 9'b0_0100_0000,
        ST_SHUTDOWN = 9'b0_1000_0000,
        ST_STARTUP = 9'b1_0000_0000
    } pms_mode_type;

    // Wake and reset sources gathered from the rest of the chip.
    typedef struct packed {
        logic ext_reset;        // external_reset_pin asserted.
        logic wdg_reset;        // independent_watchdog reset.
        logic wakeup_pin;       // Level of the wakeup_pin.
        logic rtc_event;        // Alarm, periodic wakeup or timestamp.
        logic intrusion;        // intrusion_detector event.
        logic slow_xtal_fail;   // clock_failure_detector on the slow crystal.
        logic periph_irq;       // Any peripheral interrupt or event.
    } pms_wake_type;

    // Supply comparator levels from the analog front end.
    typedef struct packed {
        logic main_above_por;   // Main supply above the power-on threshold.
        logic main_above_bor;   // Main supply above the brownout threshold.
        logic main_above_std;   // Main supply above the detector threshold.
        logic main_valid;
        logic backup_valid;
    } pms_supply_type;

    // Power and clock enables driven to the analog and clock blocks.
    typedef struct packed {
        logic main_reg_on;
        logic lp_reg_on;
        logic reg_hiz;
        logic pll_on;
        logic fast_rc_on;
        logic fast_xtal_on;
        logic slow_rc_on;
        logic cpu_clk_on;
        logic core_clk_on;
        logic sram_powered;
        logic core_state_lost;
        logic rtc_on_backup;
    } pms_power_type;

endpackage

/* hw/pms_supervisor.sv */
// Power mode supervisor: mode sequencer, supply supervision and APB registers.
// Assumes all inputs synchronous to pclk; analog comparators deliver clean levels.
`timescale 1ns/1ps

module pms_supervisor #(
    parameter int NUM_PINS = 16,
    parameter int STARTUP_LEN = pms_pkg::STARTUP_CYCLES
) (
    input wire logic pclk,                          // Bus clock, 50 MHz.
    input wire logic presetn,                       // Asynchronous reset, active low.
    input wire logic psel,                          // APB select.
    input wire logic penable,                       // APB access phase.
    input wire logic pwrite,                        // APB direction.
    input wire logic [7:0] paddr,                   // APB byte address.
    input wire logic [31:0] pwdata,                 // APB write data.
    output logic [31:0] prdata,                     // APB read data.
    output logic pready,                            // APB ready.
    output logic pslverr,                           // APB error on unmapped address.
    input wire pms_pkg::pms_wake_type wake,         // Wake and reset sources.
    input wire logic [NUM_PINS-1:0] periph_rc_req,  // Fast RC requests in Stop.
    input wire pms_pkg::pms_supply_type supply,     // Supply comparator levels.
    input wire logic bor_opt_en,                    // Option byte brownout enable.
    input wire logic [1:0] bor_opt_rise,            // Option byte rising threshold.
    input wire logic [1:0] bor_opt_fall,            // Option byte falling threshold.
    output logic [1:0] bor_thr_sel,                 // Brownout threshold to comparator.
    output logic bor_active,                        // Brownout monitor enabled.
    output logic por_active,                        // Power-on/down monitor enabled.
    output logic sys_reset_n,                       // Chip system reset, active low.
    output logic rst_pin_pullup_en,                 // Reset pin pull-up enable.
    output logic schmitt_en,                        // I/O input stage enable.
    output logic [NUM_PINS-1:0] pull_up_en,         // Pin pull-ups applied.
    output logic [NUM_PINS-1:0] pull_dn_en,         // Pin pull-downs applied.
    output logic [7:0] cpu_clk_div,                 // Processor clock divider.
    output logic std_irq,                           // Threshold detector interrupt.
    output pms_pkg::pms_power_type power            // Regulator and clock enables.
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        pms_pkg::pms_mode_type mode;
        logic [31:0] ctrl;
        logic [31:0] supv;
        logic [2*NUM_PINS-1:0] pull;
        logic std_flag;
        logic std_last;
        logic wk_last;
        logic bor_last;
        logic int_rst;
        logic [7:0] cnt;
        logic rst_done;
        logic [31:0] rdata;
        pms_pkg::pms_power_type pwr;
    } pms_state_type;

    pms_state_type st_reg;
    pms_state_type st_next;

    // Two pull bits a pin must fit one word.
    initial begin
        if (NUM_PINS < 1 || NUM_PINS > 16) begin
            $error("NUM_PINS must lie between 1 and 16.");
        end
        if (STARTUP_LEN < 1 || STARTUP_LEN > 255) begin
            $error("STARTUP_LEN must lie between 1 and 255.");
        end
    end

    // Register write decode shared by all writable registers.
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off,
                                    input logic s, input logic e, input logic w);
        wr_hit = s && e && w && (a == off);
    endfunction

    // ------------------------------------------------------------------
    // Combinational next state
    // ------------------------------------------------------------------
    // These terms feed the sequencer, the crossing flag, the reset cause and the outputs.
    logic mapped;
    logic wk_edge;
    logic std_fall;
    logic std_rise;
    logic bor_ok;
    logic on_battery;
    logic deep_wake_sb;
    logic deep_wake_sd;
    logic go;
    logic [2:0] req;
    logic [7:0] div;

    always_comb begin
        st_next = st_reg;
        mapped = (paddr == pms_pkg::OFF_CTRL) || (paddr == pms_pkg::OFF_SUPV) ||
                 (paddr == pms_pkg::OFF_STAT) || (paddr == pms_pkg::OFF_PULL) ||
                 (paddr == pms_pkg::OFF_CLR);
        // Polarity bit picks which wakeup pin edge counts.
        wk_edge = st_reg.ctrl[pms_pkg::CTRL_WKPOL_BIT] ?
                  (st_reg.wk_last && !wake.wakeup_pin) :
                  (!st_reg.wk_last && wake.wakeup_pin);
        std_fall = st_reg.std_last && !supply.main_above_std;
        std_rise = !st_reg.std_last && supply.main_above_std;
        bor_ok = !bor_opt_en || supply.main_above_bor;
        on_battery = !supply.main_valid && supply.backup_valid;
        // Wakeup pin, RTC and intrusion events are blocked on battery only operation.
        deep_wake_sb = wake.ext_reset || wake.wdg_reset ||
                       (!on_battery && (wk_edge || wake.rtc_event || wake.intrusion)) ||
                       wake.slow_xtal_fail;
        deep_wake_sd = wake.ext_reset ||
                       (!on_battery && (wk_edge || wake.rtc_event || wake.intrusion));
        req = st_reg.ctrl[pms_pkg::CTRL_MODE_LSB +: 3];
        go = wr_hit(paddr, pms_pkg::OFF_CTRL, psel, penable, pwrite) &&
             pwdata[pms_pkg::CTRL_GO_BIT];
        st_next.wk_last = wake.wakeup_pin;
        st_next.std_last = supply.main_above_std;
        st_next.bor_last = bor_ok;
        // Inputs stay off until this first edge.
        st_next.rst_done = 1'b1;

        // Register writes; the go bit is a strobe and never stored.
        // Unmapped writes change nothing.
        if (wr_hit(paddr, pms_pkg::OFF_CTRL, psel, penable, pwrite)) begin
            st_next.ctrl = pwdata & ~(32'h0000_0001 << pms_pkg::CTRL_GO_BIT);
        end
        if (wr_hit(paddr, pms_pkg::OFF_SUPV, psel, penable, pwrite)) begin
            st_next.supv = pwdata & ~(32'h0000_0001 << pms_pkg::SUPV_FLAG_BIT);
        end
        if (wr_hit(paddr, pms_pkg::OFF_PULL, psel, penable, pwrite)) begin
            st_next.pull = pwdata[2*NUM_PINS-1:0];
        end
        // A crossing in the clearing cycle wins over the clear.
        if (wr_hit(paddr, pms_pkg::OFF_CLR, psel, penable, pwrite) &&
            pwdata[pms_pkg::CLR_FLAG_BIT]) begin
            st_next.std_flag = 1'b0;
        end
        if (st_reg.supv[pms_pkg::SUPV_STD_EN_BIT] &&
            ((std_fall && st_reg.supv[pms_pkg::SUPV_FALL_BIT]) ||
             (std_rise && st_reg.supv[pms_pkg::SUPV_RISE_BIT]))) begin
            st_next.std_flag = 1'b1;
        end

        // Read data is latched in the setup cycle and presented in the access phase.
        // Unmapped reads give zero.
        case (paddr)
            pms_pkg::OFF_CTRL: st_next.rdata = st_reg.ctrl;
            pms_pkg::OFF_SUPV: st_next.rdata = st_reg.supv |
                ({31'h0000_0000, st_reg.std_flag} << pms_pkg::SUPV_FLAG_BIT);
            pms_pkg::OFF_STAT: st_next.rdata = {23'h00_0000, st_reg.mode};
            pms_pkg::OFF_PULL: st_next.rdata = 32'(st_reg.pull);
            default: st_next.rdata = 32'h0000_0000;
        endcase

        // Mode sequencer.
        case (st_reg.mode)
            pms_pkg::ST_RUN: begin
                // Go uses the fields of its own write.
                if (go) begin
                    case (pwdata[pms_pkg::CTRL_MODE_LSB +: 3])
                        pms_pkg::REQ_SLEEP: st_next.mode = pms_pkg::ST_SLEEP;
                        pms_pkg::REQ_STOP0: st_next.mode = pms_pkg::ST_STOP0;
                        pms_pkg::REQ_STOP1: st_next.mode = pms_pkg::ST_STOP1;
                        pms_pkg::REQ_STANDBY: st_next.mode = pms_pkg::ST_STANDBY;
                        pms_pkg::REQ_SHUTDOWN: st_next.mode = pms_pkg::ST_SHUTDOWN;
                        default: st_next.mode = pwdata[pms_pkg::CTRL_LPRUN_BIT] ?
                                                pms_pkg::ST_LPRUN : pms_pkg::ST_RUN;
                    endcase
                end
            end
            pms_pkg::ST_LPRUN: begin
                // Only sleep or a return to Run leave low-power run.
                if (go && pwdata[pms_pkg::CTRL_MODE_LSB +: 3] == pms_pkg::REQ_SLEEP) begin
                    st_next.mode = pms_pkg::ST_LPSLEEP;
                end else if (go && !pwdata[pms_pkg::CTRL_LPRUN_BIT]) begin
                    st_next.mode = pms_pkg::ST_RUN;
                end
            end
            pms_pkg::ST_SLEEP: begin
                // Peripherals run on and wake it.
                if (wake.periph_irq) begin
                    st_next.mode = pms_pkg::ST_RUN;
                end
            end
            pms_pkg::ST_LPSLEEP: begin
                // It returns to low-power run, not Run.
                if (wake.periph_irq) begin
                    st_next.mode = pms_pkg::ST_LPRUN;
                end
            end
            pms_pkg::ST_STOP0, pms_pkg::ST_STOP1: begin
                // State was kept; the wake goes to Run.
                if (wake.periph_irq || wake.ext_reset) begin
                    st_next.mode = pms_pkg::ST_RUN;
                end
            end
            pms_pkg::ST_STANDBY: begin
                // Pull choices survive the wake.
                if (deep_wake_sb) begin
                    st_next.mode = pms_pkg::ST_STARTUP;
                    st_next.cnt = 8'(STARTUP_LEN);
                end
            end
            pms_pkg::ST_SHUTDOWN: begin
                if (deep_wake_sd) begin
                    st_next.mode = pms_pkg::ST_STARTUP;
                    // Shutdown keeps no pull choice.
                    st_next.pull = '0;
                    st_next.cnt = 8'(STARTUP_LEN);
                end
            end
            pms_pkg::ST_STARTUP: begin
                // Core state was lost, so control and supervisor registers return to reset values.
                st_next.ctrl = pms_pkg::CTRL_RESET;
                st_next.supv = pms_pkg::SUPV_RESET;
                st_next.std_flag = 1'b0;
                // Reset holds for STARTUP_LEN cycles.
                st_next.cnt = st_reg.cnt - 8'h01;
                if (st_reg.cnt == 8'h01) begin
                    st_next.mode = pms_pkg::ST_RUN;
                end
            end
            default: st_next.mode = pms_pkg::ST_RUN;
        endcase

        // Internal reset causes: watchdog or a brownout falling edge.
        // An outside reset keeps the pull-up.
        st_next.int_rst = wake.wdg_reset || (st_reg.bor_last && !bor_ok);

        // Power and clock enables follow the next mode.
        // Slow RC runs except in Shutdown.
        st_next.pwr = '0;
        st_next.pwr.slow_rc_on = 1'b1;
        st_next.pwr.rtc_on_backup = !supply.main_valid && supply.backup_valid;
        case (st_next.mode)
            pms_pkg::ST_RUN, pms_pkg::ST_SLEEP: begin
                // Full speed keeps the PLL and fast clocks.
                st_next.pwr.main_reg_on = 1'b1;
                st_next.pwr.pll_on = 1'b1;
                st_next.pwr.fast_rc_on = 1'b1;
                st_next.pwr.fast_xtal_on = 1'b1;
                st_next.pwr.core_clk_on = 1'b1;
                st_next.pwr.cpu_clk_on = (st_next.mode == pms_pkg::ST_RUN);
                st_next.pwr.sram_powered = 1'b1;
            end
            pms_pkg::ST_LPRUN, pms_pkg::ST_LPSLEEP: begin
                // The divider clamp caps the CPU.
                st_next.pwr.lp_reg_on = 1'b1;
                st_next.pwr.fast_rc_on = 1'b1;
                st_next.pwr.core_clk_on = 1'b1;
                st_next.pwr.cpu_clk_on = (st_next.mode == pms_pkg::ST_LPRUN);
                st_next.pwr.sram_powered = 1'b1;
            end
            pms_pkg::ST_STOP0, pms_pkg::ST_STOP1: begin
                st_next.pwr.main_reg_on = (st_next.mode == pms_pkg::ST_STOP0);
                st_next.pwr.lp_reg_on = 1'b1;
                // A wake peripheral may keep it.
                st_next.pwr.fast_rc_on = |periph_rc_req;
                st_next.pwr.sram_powered = 1'b1;
            end
            pms_pkg::ST_STANDBY: begin
                st_next.pwr.reg_hiz = 1'b1;
                // The entering write's retention bit counts at once.
                st_next.pwr.lp_reg_on = st_next.ctrl[pms_pkg::CTRL_RET_BIT];
                st_next.pwr.sram_powered = st_next.ctrl[pms_pkg::CTRL_RET_BIT];
                st_next.pwr.core_state_lost = 1'b1;
            end
            pms_pkg::ST_SHUTDOWN: begin
                st_next.pwr.reg_hiz = 1'b1;
                // Nothing monitors, so the RTC stays off backup.
                st_next.pwr.slow_rc_on = 1'b0;
                st_next.pwr.rtc_on_backup = 1'b0;
                st_next.pwr.core_state_lost = 1'b1;
            end
            default: begin
                // Start-up uses the main regulator.
                st_next.pwr.main_reg_on = 1'b1;
                st_next.pwr.fast_rc_on = 1'b1;
                st_next.pwr.core_state_lost = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset loads constants only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.mode <= pms_pkg::ST_RUN;
            st_reg.ctrl <= pms_pkg::CTRL_RESET;
            st_reg.supv <= pms_pkg::SUPV_RESET;
            st_reg.pull <= '0;
            st_reg.wk_last <= 1'b0;
            st_reg.pwr <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // APB answers with no wait states; unmapped addresses give an error.
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    // It comes from a flop and stands all access.
    assign prdata = st_reg.rdata;
    assign power = st_reg.pwr;
    // Sticky until software clears it or start-up after a deep wake resets it.
    assign std_irq = st_reg.std_flag;

    // Low-power run clamps the divider so the processor never exceeds 2 MHz.
    // Used as written outside low-power run and low-power sleep.
    assign div = st_reg.ctrl[pms_pkg::CTRL_CLKDIV_LSB +: 8];
    assign cpu_clk_div = (st_reg.mode == pms_pkg::ST_LPRUN ||
                          st_reg.mode == pms_pkg::ST_LPSLEEP) &&
                         (div < 8'(pms_pkg::LPRUN_MIN_DIV)) ?
                         8'(pms_pkg::LPRUN_MIN_DIV) : div;

    // Option bytes drive the brownout monitor; it is off in Shutdown.
    assign bor_active = bor_opt_en && (st_reg.mode != pms_pkg::ST_SHUTDOWN);
    // Above the level the fall code is used.
    assign bor_thr_sel = supply.main_above_bor ? bor_opt_fall : bor_opt_rise;
    assign por_active = (st_reg.mode != pms_pkg::ST_SHUTDOWN);

    // Reset is held below the power-on threshold outside Shutdown and during start-up.
    // Brownout counts only when enabled.
    assign sys_reset_n = st_reg.rst_done && (st_reg.mode != pms_pkg::ST_STARTUP) &&
                         (!por_active || supply.main_above_por) &&
                         !(bor_active && !supply.main_above_bor);
    // Input stages also wait for rst_done.
    assign schmitt_en = sys_reset_n && st_reg.rst_done;
    assign rst_pin_pullup_en = !st_reg.int_rst;

    // Standby pull choices apply only while Standby is in effect.
    always_comb begin
        pull_up_en = '0;
        pull_dn_en = '0;
        if (st_reg.mode == pms_pkg::ST_STANDBY) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                pull_up_en[i] = st_reg.pull[2*i];
                // Pull-up wins over pull-down.
                pull_dn_en[i] = st_reg.pull[2*i+1] && !st_reg.pull[2*i];
            end
        end
    end

endmodule

/* tb/pms_far_side.sv */
// Far-side model: the wake sources and supply comparators around the block.
// Assumes the bench sends one command code per pulse, synchronous to pclk.
`timescale 1ns/1ps
module pms_far_side (
    input wire logic pclk, // Bus clock.
    input wire logic [3:0] cmd, // 0 idle, 1-7 wake bit, 8 supply loss.
    output pms_pkg::pms_wake_type wake, // Wake levels.
    output pms_pkg::pms_supply_type supply // Comparator levels.
);
    // Sources pulse for one cycle so edge detection is exercised too.
    always_ff @(posedge pclk) begin
        wake <= (cmd inside {[4'h1:4'h7]}) ? 7'h01 << (cmd - 4'h1) : 7'h00;
        supply <= (cmd == 4'h8) ? 5'h01 : 5'h1F;
    end
endmodule

/* tb/pms_supervisor_monitor.sv */
// Checker for the supervisor, bound onto its top-level ports.
// Assumes pms_pkg is compiled first.
`timescale 1ns/1ps
module pms_supervisor_monitor #(parameter int NUM_PINS = 16) (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset, active low.
    input wire pms_pkg::pms_supply_type supply, // Supply levels.
    input wire logic bor_active, // Brownout on.
    input wire logic por_active, // Power-on monitor on.
    input wire logic sys_reset_n, // System reset.
    input wire logic schmitt_en, // Input stages.
    input wire logic [NUM_PINS-1:0] pull_up_en, // Pull-ups.
    input wire logic [NUM_PINS-1:0] pull_dn_en, // Pull-downs.
    input wire logic [7:0] cpu_clk_div, // Divider.
    input wire pms_pkg::pms_power_type power // Enables.
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_por_hold: assert property (!supply.main_above_por && por_active |-> !sys_reset_n)
        else $error("reset not held at low supply");
    a_bor_shut: assert property (!por_active |-> !bor_active)
        else $error("brownout on in shutdown");
    a_schmitt_off: assert property (!sys_reset_n |-> !schmitt_en)
        else $error("input stage on in reset");
    a_schmitt_rel: assert property ($rose(presetn) |-> !schmitt_en && !sys_reset_n)
        else $error("input stage on at reset release");
    a_reg_hiz: assert property (power.reg_hiz |-> !power.main_reg_on && !power.pll_on)
        else $error("regulator on while off");
    a_stop_osc: assert property (power.lp_reg_on && !power.core_clk_on |-> !power.pll_on)
        else $error("pll on in stop");
    a_rtc_main: assert property (supply.main_valid |=> !power.rtc_on_backup)
        else $error("rtc on backup");
    a_pull_stby: assert property (|{pull_up_en, pull_dn_en} |->
        power.reg_hiz && power.slow_rc_on)
        else $error("pull outside standby");
    a_lp_div: assert property (power.lp_reg_on && power.cpu_clk_on |-> cpu_clk_div >= 8'h19)
        else $error("cpu clock too fast");
    // Main scenarios: deep mode, low-power run and a reset release.
    cover property (power.reg_hiz);
    cover property (power.lp_reg_on && power.cpu_clk_on);
    cover property (!sys_reset_n ##1 sys_reset_n);
endmodule
bind pms_supervisor pms_supervisor_monitor #(.NUM_PINS(NUM_PINS)) u_mon (.pclk, .presetn,
    .supply, .bor_active, .por_active, .sys_reset_n, .schmitt_en, .pull_up_en, .pull_dn_en,
    .cpu_clk_div, .power);

/* tb/testbench.sv */
// Bench for the supervisor: mode scenarios driven over APB.
// Assumes pms_pkg, the far-side model and the checker are compiled.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED %0t got %h", $time, a); end end
module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, div;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic [3:0] cmd = 4'h0;
    logic [15:0] rc_req = 16'h0000, pu, pd;
    logic [1:0] thr;
    logic pready, pslverr, bor_a, por_a, sr_n, sch, irq, pup, err;
    pms_pkg::pms_wake_type wake;
    pms_pkg::pms_supply_type supply;
    pms_pkg::pms_power_type power;
    int n_fail = 0, num_checks = 0, cyc = 0;
    pms_far_side u_far (.pclk, .cmd, .wake, .supply);
    pms_supervisor #(.STARTUP_LEN(2)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .wake, .periph_rc_req(rc_req), .supply,
        .bor_opt_en(1'b1), .bor_opt_rise(2'h1), .bor_opt_fall(2'h2), .bor_thr_sel(thr),
        .bor_active(bor_a), .por_active(por_a), .sys_reset_n(sr_n), .rst_pin_pullup_en(pup),
        .schmitt_en(sch), .pull_up_en(pu), .pull_dn_en(pd), .cpu_clk_div(div), .std_irq(irq),
        .power);
    initial forever #10 pclk = ~pclk;
    // A hang counts as a mismatch and closes the run.
    always @(posedge pclk) if (++cyc == 20000) begin
        n_fail++;
        results();
    end
    // The request stands until pready is seen high at a rising edge; data are taken there.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(q, e)
    endtask
    task automatic go(input logic [31:0] c);
        bus(1'b1, 8'h00, c);
    endtask
    task automatic ev(input logic [3:0] c);
        @(posedge pclk);
        cmd <= c;
        @(posedge pclk);
        cmd <= 4'h0;
        repeat (8) @(posedge pclk);
    endtask
    task automatic t_modes;
        rd(8'h08, 32'h0000_0001);
        `CHK({power.main_reg_on, sch, thr}, 4'hE)
        go(32'h0000_0009);
        rd(8'h08, 32'h0000_0002);
        `CHK({power.cpu_clk_on, power.core_clk_on}, 2'h1)
        ev(4'h1);
        rd(8'h08, 32'h0000_0001);
        go(32'h0000_0048);
        rd(8'h08, 32'h0000_0004);
        `CHK({div, power.lp_reg_on}, 9'h033)
        go(32'h0000_0049);
        rd(8'h08, 32'h0000_0008);
        ev(4'h1);
        rd(8'h08, 32'h0000_0004);
        go(32'h0000_0008);
        $display("end modes");
    endtask
    task automatic t_stop;
        go(32'h0000_000B);
        rc_req <= 16'h0001;
        rd(8'h08, 32'h0000_0020);
        `CHK({power.main_reg_on, power.pll_on, power.fast_rc_on}, 3'h1)
        rc_req <= 16'h0000;
        ev(4'h1);
        go(32'h0000_000A);
        rd(8'h08, 32'h0000_0010);
        `CHK({power.main_reg_on, power.fast_rc_on}, 2'h2)
        ev(4'h1);
        rd(8'h08, 32'h0000_0001);
        $display("end stop");
    endtask
    task automatic t_deep;
        bus(1'b1, 8'h0C, 32'h0000_0001);
        go(32'h0000_001C);
        rd(8'h08, 32'h0000_0040);
        `CHK({pu[0], pd[0], power.sram_powered, power.main_reg_on}, 4'hA)
        for (int k = 2; k < 8; k++) begin
            ev(4'(k));
            rd(8'h08, 32'h0000_0001);
            rd(8'h0C, 32'h0000_0001);
            go(32'h0000_000C);
        end
        ev(4'h1);
        rd(8'h08, 32'h0000_0040);
        ev(4'h7);
        go(32'h0000_000D);
        rd(8'h08, 32'h0000_0080);
        `CHK({bor_a, por_a, power.slow_rc_on}, 3'h0)
        ev(4'h6);
        rd(8'h08, 32'h0000_0080);
        ev(4'h4);
        rd(8'h08, 32'h0000_0001);
        rd(8'h0C, 32'h0000_0000);
        rd(8'h14, 32'h0000_0000);
        `CHK(err, 1'b1)
        bus(1'b1, 8'h04, 32'h0000_0003);
        @(posedge pclk);
        cmd <= 4'h8;
        repeat (2) @(posedge pclk);
        `CHK(sr_n, 1'b0)
        @(posedge pclk);
        `CHK({pup, irq}, 2'h1)
        cmd <= 4'h0;
        rd(8'h04, 32'h0000_000B);
        bus(1'b1, 8'h10, 32'h0000_0001);
        rd(8'h04, 32'h0000_0003);
        repeat (8) @(posedge pclk);
        $display("end deep");
    endtask
    task automatic results;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        `CHK(sch, 1'b0)
        presetn <= 1'b1;
        t_modes();
        t_stop();
        t_deep();
        results();
    end
endmodule
